// ---- src/serializer_mode_control.sv ----
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
module serializer_mode_control
    import serializer_mode_control_pkg::*;
#(
    parameter int LANES = LANE_COUNT
) (
    input  wire logic                   clk_sys_in,
    input  wire logic                   reset_n_in,
    input  wire logic [1:0]             mode_strap_in,
    input  wire logic                   lane_bit_map_select_in,
    input  wire logic                   power_down_n_in,
    input  wire logic                   self_test_enable_in,
    input  wire logic                   output_swing_select_in,
    input  wire logic                   emphasis_control_in,
    input  wire logic [7:0]             reserved_inputs_in,
    input  wire logic [STRAP_WIDTH-1:0] bus_address_strap_in,
    input  wire logic [LANES-1:0]       parallel_data_lanes_in,
    input  wire logic                   parallel_clock_lane_in,
    input  wire logic [ADDR_WIDTH-1:0]  reg_addr_in,
    input  wire logic [DATA_WIDTH-1:0]  reg_wdata_in,
    input  wire logic                   reg_write_in,
    input  wire logic                   reg_read_in,
    output logic [DATA_WIDTH-1:0]       reg_rdata_out,
    output logic [1:0]                  link_mode_out,
    output logic                        filter_enable_out,
    output logic                        legacy_mode_out,
    output logic                        lane_map_msb_out,
    output logic                        serializer_enable_out,
    output logic                        pll_enable_out,
    output logic                        serial_p_out,
    output logic                        serial_n_out,
    output logic                        self_test_active_out,
    output logic                        swing_high_out,
    output logic                        emphasis_enable_out,
    output logic [STRAP_WIDTH-1:0]      bus_address_out,
    output logic [LANES-1:0]            lane_data_out,
    output logic                        lane_clock_out
);

    initial begin
        if (LANES != LANE_COUNT) begin
            $error("Lane count must be four");
        end
    end

    typedef struct packed {
        run_state_t             run;
        logic [7:0]             ctrl0_reg;
        logic [7:0]             ctrl1_reg;
        logic [DATA_WIDTH-1:0]  rdata;
        logic [1:0]             mode;
        logic                   filt;
        logic                   legacy;
        logic                   map_msb;
        logic                   ser_en;
        logic                   pll_en;
        logic                   sp;
        logic                   sn;
        logic                   test;
        logic                   swing;
        logic                   emph;
        logic [STRAP_WIDTH-1:0] addr;
        logic                   addr_taken;
        logic [LANES-1:0]       lanes;
        logic                   lclk;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Register side wins over straps only while override bit is set
    function automatic logic pick(input logic ovr, input logic reg_bit, input logic pin_bit);
        pick = ovr ? reg_bit : pin_bit;
    endfunction : pick

    //////////////////////////////////////////////////////////////////////////////////////////////////
    logic       ovr;
    logic [1:0] mode_sel;
    logic       up;

    always_comb begin
        state_next = state_reg;
        ovr        = state_reg.ctrl0_reg[CTRL0_OVR_BIT];
        up         = power_down_n_in;
        // Pins arrive already resolved; pulldowns make undriven straps read low
        mode_sel   = ovr ? state_reg.ctrl0_reg[CTRL0_MODE_LSB +: 2] : mode_strap_in;

        // Reads answer next cycle; unmapped reads as zero
        state_next.rdata = '0;
        if (reg_read_in) begin
            case (reg_addr_in)
                CTRL0_OFFSET:  state_next.rdata = state_reg.ctrl0_reg;
                CTRL1_OFFSET:  state_next.rdata = state_reg.ctrl1_reg;
                STATUS_OFFSET: state_next.rdata = {3'h0, state_reg.test, state_reg.ser_en,
                                                   state_reg.legacy, state_reg.mode};
                ADDR_OFFSET:   state_next.rdata = {{(DATA_WIDTH-STRAP_WIDTH){1'b0}}, state_reg.addr};
                default:       state_next.rdata = '0;
            endcase
        end
        if (reg_write_in && up) begin
            case (reg_addr_in)
                CTRL0_OFFSET: state_next.ctrl0_reg = reg_wdata_in & CTRL0_MASK;
                CTRL1_OFFSET: state_next.ctrl1_reg = reg_wdata_in & CTRL1_MASK;
                default:      state_next.ctrl0_reg = state_reg.ctrl0_reg;
            endcase
        end

        // Address strap sampled once after reset release; a later change needs a reset
        if (!state_reg.addr_taken) begin
            state_next.addr       = bus_address_strap_in;
            state_next.addr_taken = 1'b1;
        end

        state_next.mode    = mode_sel;
        state_next.filt    = (mode_sel == MODE_CURRENT_FILT);
        state_next.legacy  = (mode_sel == MODE_LEGACY_A) || (mode_sel == MODE_LEGACY_B);
        state_next.map_msb = pick(ovr, state_reg.ctrl1_reg[CTRL1_MAP_BIT], lane_bit_map_select_in);
        state_next.swing   = pick(ovr, state_reg.ctrl0_reg[CTRL0_SWING_BIT], output_swing_select_in);
        // Pin is active low: resistor to ground pulls it low
        state_next.emph    = !emphasis_control_in || state_reg.ctrl1_reg[CTRL1_EMPH_BIT];

        case (state_reg.run)
            ST_DOWN: begin
                if (up) begin
                    state_next.run = ST_NORMAL;
                end
            end
            ST_NORMAL: begin
                if (!up) begin
                    state_next.run = ST_DOWN;
                end else if (self_test_enable_in || state_reg.ctrl1_reg[CTRL1_TEST_BIT]) begin
                    state_next.run = ST_TEST;
                end
            end
            ST_TEST: begin
                if (!up) begin
                    state_next.run = ST_DOWN;
                end else if (!self_test_enable_in && !state_reg.ctrl1_reg[CTRL1_TEST_BIT]) begin
                    state_next.run = ST_NORMAL;
                end
            end
            default: state_next.run = ST_DOWN;
        endcase

        if (!up) begin
            state_next.ctrl0_reg = CTRL0_RESET;
            state_next.ctrl1_reg = CTRL1_RESET;
        end

        state_next.ser_en = up;
        state_next.pll_en = up;
        state_next.test   = up && (state_next.run == ST_TEST);
        // Lane 0 stands in for the serial stream; the real encoder is elsewhere
        state_next.lanes  = parallel_data_lanes_in;
        state_next.lclk   = parallel_clock_lane_in;
        if (up) begin
            state_next.sp = parallel_data_lanes_in[0];
            state_next.sn = !parallel_data_lanes_in[0];
        end else begin
            state_next.sp = 1'b1;
            state_next.sn = 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg           <= '0;
            state_reg.run       <= ST_DOWN;
            state_reg.ctrl0_reg <= CTRL0_RESET;
            state_reg.ctrl1_reg <= CTRL1_RESET;
            state_reg.sp        <= 1'b1;
            state_reg.sn        <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Reserved inputs have no function; held low by the board
    logic unused_reserved;
    assign unused_reserved = ^reserved_inputs_in;

    assign reg_rdata_out         = state_reg.rdata;
    assign link_mode_out         = state_reg.mode;
    assign filter_enable_out     = state_reg.filt;
    assign legacy_mode_out       = state_reg.legacy;
    assign lane_map_msb_out      = state_reg.map_msb;
    assign serializer_enable_out = state_reg.ser_en;
    assign pll_enable_out        = state_reg.pll_en;
    assign serial_p_out          = state_reg.sp;
    assign serial_n_out          = state_reg.sn;
    assign self_test_active_out  = state_reg.test;
    assign swing_high_out        = state_reg.swing;
    assign emphasis_enable_out   = state_reg.emph;
    assign bus_address_out       = state_reg.addr;
    assign lane_data_out         = state_reg.lanes;
    assign lane_clock_out        = state_reg.lclk;

endmodule : serializer_mode_control

// ---- src/serializer_mode_control_pkg.sv ----
//////////////////////////////////////////////////////////////////////////////////////////////////////
// Function
// - Two-bit mode selection comes from strap pins or a control register.
// - Mode 00 targets current companion deserializer, control-signal filter off.
// - Mode 01 targets current companion deserializer, control-signal filter on.
// - Mode 10 and 11 select two different legacy deserializer compatibilities.
// - Map select 1 puts MSBs on lane 3; 0 puts LSBs there.
// - Accept four parallel data lanes 3..0 plus one timing clock lane.
// - Power-down input high means normal operation with serialization enabled.
// - Power-down input low drives both serial outputs high, PLL off.
// - Entering power-down returns every control register to reset value.
// - Self-test enable 1 starts self-test; 0 keeps normal operation. Here register 0x04 bit 2 set also starts self-test with the pin at 0.
// - Swing select 1 gives 900 mVp-p; 0 gives 600 mVp-p.
// - De-emphasis off when pin floats; on with resistor or register enable.
// - Serial bus address is taken from the address strap level.
// - Register 0x00 bits 3:2 hold the register-controlled mode selection.
// - Register 0x00 bit 5 holds the register-controlled swing select.
//////////////////////////////////////////////////////////////////////////////////////////////////////
package serializer_mode_control_pkg;

    localparam logic [7:0] CTRL0_OFFSET      = 8'h00;
    localparam logic [7:0] CTRL1_OFFSET      = 8'h04;
    localparam logic [7:0] STATUS_OFFSET     = 8'h08;
    localparam logic [7:0] ADDR_OFFSET       = 8'h0c;

    localparam int         CTRL0_OVR_BIT     = 0;
    localparam int         CTRL0_MODE_LSB    = 2;
    localparam int         CTRL0_SWING_BIT   = 5;
    localparam int         CTRL1_MAP_BIT     = 0;
    localparam int         CTRL1_EMPH_BIT    = 1;
    localparam int         CTRL1_TEST_BIT    = 2;

    localparam logic [7:0] CTRL0_RESET       = 8'h00;
    localparam logic [7:0] CTRL1_RESET       = 8'h00;
    localparam logic [7:0] CTRL0_MASK        = 8'h2d;
    localparam logic [7:0] CTRL1_MASK        = 8'h07;

    localparam int         ADDR_WIDTH        = 8;
    localparam int         DATA_WIDTH        = 8;
    localparam int         LANE_COUNT        = 4;
    localparam int         STRAP_WIDTH       = 4;

    typedef enum logic [1:0] {
        MODE_CURRENT_NOFILT = 2'h0,
        MODE_CURRENT_FILT   = 2'h1,
        MODE_LEGACY_A       = 2'h2,
        MODE_LEGACY_B       = 2'h3
    } link_mode_t;

    typedef enum logic [1:0] {
        ST_DOWN   = 2'h0,
        ST_NORMAL = 2'h1,
        ST_TEST   = 2'h3
    } run_state_t;

endpackage : serializer_mode_control_pkg

// ---- test/lane_source.sv ----
`timescale 1ns/1ps
module lane_source (
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    output logic [3:0]      parallel_data_lanes_in,
    output logic            parallel_clock_lane_in,
    output logic [7:0]      reserved_inputs_in
);
    // Pattern changes every cycle so a stuck lane shows
    assign reserved_inputs_in = 8'h00;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            parallel_data_lanes_in <= 4'h0;
            parallel_clock_lane_in <= 1'b0;
        end else begin
            parallel_data_lanes_in <= parallel_data_lanes_in + 4'h3;
            parallel_clock_lane_in <= ~parallel_clock_lane_in;
        end
    end
endmodule : lane_source

// ---- test/serializer_mode_control_chk.sv ----
`timescale 1ns/1ps
module serializer_mode_control_chk #(
    parameter int LANES = 4
) (
    input  wire logic             clk_sys_in,
    input  wire logic             reset_n_in,
    input  wire logic             power_down_n_in,
    input  wire logic             self_test_enable_in,
    input  wire logic             emphasis_control_in,
    input  wire logic [LANES-1:0] parallel_data_lanes_in,
    input  wire logic             parallel_clock_lane_in,
    input  wire logic [7:0]       reg_addr_in,
    input  wire logic [7:0]       reg_wdata_in,
    input  wire logic             reg_write_in,
    input  wire logic             reg_read_in,
    input  wire logic [7:0]       reg_rdata_out,
    input  wire logic [1:0]       link_mode_out,
    input  wire logic             filter_enable_out,
    input  wire logic             legacy_mode_out,
    input  wire logic             serializer_enable_out,
    input  wire logic             pll_enable_out,
    input  wire logic             serial_p_out,
    input  wire logic             serial_n_out,
    input  wire logic             self_test_active_out,
    input  wire logic             emphasis_enable_out,
    input  wire logic             swing_high_out,
    input  wire logic [3:0]       bus_address_out,
    input  wire logic [LANES-1:0] lane_data_out,
    input  wire logic             lane_clock_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    a_run_enables: assert property (power_down_n_in |=> serializer_enable_out && pll_enable_out)
        else $error("enables low while running");
    a_down_outputs: assert property (!power_down_n_in |=> serial_p_out && serial_n_out && !pll_enable_out)
        else $error("power-down outputs wrong");
    a_serial_lane: assert property (power_down_n_in |=> serial_p_out == $past(parallel_data_lanes_in[0]) && serial_n_out != serial_p_out)
        else $error("serial pair wrong while running");
    a_filter_mode: assert property (filter_enable_out == (link_mode_out == 2'h1))
        else $error("filter does not match mode");
    a_legacy_mode: assert property (legacy_mode_out == link_mode_out[1])
        else $error("legacy flag does not match mode");
    a_lane_delay: assert property (1'b1 |=> lane_data_out == $past(parallel_data_lanes_in) && lane_clock_out == $past(parallel_clock_lane_in))
        else $error("lanes not passed through");
    a_emph_pin: assert property (!emphasis_control_in && power_down_n_in |=> emphasis_enable_out)
        else $error("emphasis off with pin tied low");
    a_test_start: assert property ((self_test_enable_in && power_down_n_in) [*3] |=> self_test_active_out)
        else $error("self-test not entered");
    a_rdata_idle: assert property (!reg_read_in |=> reg_rdata_out == 8'h00)
        else $error("read data outside read answer");
    a_addr_held: assert property ($past(reset_n_in, 2) |-> $stable(bus_address_out))
        else $error("bus address changed");
    a_write_effect: assert property (reg_write_in && reg_addr_in == 8'h00 && reg_wdata_in == 8'h2d && power_down_n_in
        ##1 power_down_n_in |=> link_mode_out == 2'h3 && swing_high_out)
        else $error("register mode write not applied");
endmodule : serializer_mode_control_chk
bind serializer_mode_control serializer_mode_control_chk #(.LANES(LANES)) chk (.*);

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import serializer_mode_control_pkg::*;
    logic clk_sys_in = 1'b0, reset_n_in = 1'b0, lane_bit_map_select_in = 1'b0, power_down_n_in = 1'b1;
    logic self_test_enable_in = 1'b0, output_swing_select_in = 1'b0, emphasis_control_in = 1'b1;
    logic reg_write_in = 1'b0, reg_read_in = 1'b0;
    logic [1:0] mode_strap_in = 2'h0;
    logic [3:0] bus_address_strap_in = 4'h9;
    logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reserved_inputs_in, reg_rdata_out, rd;
    logic [3:0] parallel_data_lanes_in, bus_address_out, lane_data_out;
    logic [1:0] link_mode_out;
    logic parallel_clock_lane_in, filter_enable_out, legacy_mode_out, lane_map_msb_out, serializer_enable_out;
    logic pll_enable_out, serial_p_out, serial_n_out, self_test_active_out, swing_high_out, emphasis_enable_out;
    logic lane_clock_out;
    int num_errors = 0, num_checks = 0;
    always #50 clk_sys_in = ~clk_sys_in;
    lane_source src (.clk_in(clk_sys_in), .reset_n_in(reset_n_in), .parallel_data_lanes_in(parallel_data_lanes_in),
        .parallel_clock_lane_in(parallel_clock_lane_in), .reserved_inputs_in(reserved_inputs_in));
    serializer_mode_control DUT (.*);
    //////////////////////////////////////////////////////////////////////////////
    task check(input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask : check
    task settle;
        repeat (2) @(posedge clk_sys_in);
        #1;
    endtask : settle
    task reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_write_in <= 1'b1; reg_addr_in <= a; reg_wdata_in <= d;
        @(posedge clk_sys_in);
        reg_write_in <= 1'b0;
    endtask : reg_write
    task reg_read(input logic [7:0] a);
        @(posedge clk_sys_in);
        reg_read_in <= 1'b1; reg_addr_in <= a;
        @(posedge clk_sys_in);
        reg_read_in <= 1'b0;
        #1 rd = reg_rdata_out;
    endtask : reg_read
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        settle;
        check(8'h09, {4'h0, bus_address_out});
        check(8'h01, {7'h0, pll_enable_out & serializer_enable_out});
        reg_read(CTRL0_OFFSET); check(CTRL0_RESET, rd);
        reg_read(CTRL1_OFFSET); check(CTRL1_RESET, rd);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            mode_strap_in <= 2'(i);
            settle;
            check(8'(i), {6'h0, link_mode_out});
            check(8'(i == 1), {7'h0, filter_enable_out});
            check(8'(i / 2), {7'h0, legacy_mode_out});
        end
        mode_strap_in <= 2'h0;
        for (int i = 0; i < 2; i++) begin
            lane_bit_map_select_in <= 1'(1 - i); output_swing_select_in <= 1'(1 - i); emphasis_control_in <= 1'(i);
            settle;
            check(8'(1 - i), {7'h0, lane_map_msb_out});
            check(8'(1 - i), {7'h0, swing_high_out});
            check(8'(1 - i), {7'h0, emphasis_enable_out});
        end
        $display("test pins done");
        // Unused bits must read back as zero
        reg_write(CTRL0_OFFSET, 8'hff); reg_read(CTRL0_OFFSET); check(CTRL0_MASK, rd);
        settle;
        check(8'h03, {6'h0, link_mode_out});
        check(8'h01, {7'h0, swing_high_out});
        reg_read(STATUS_OFFSET); check(8'h0f, rd);
        reg_read(ADDR_OFFSET); check(8'h09, rd);
        reg_write(CTRL1_OFFSET, 8'h02); settle; check(8'h01, {7'h0, emphasis_enable_out});
        reg_read(8'h10); check(8'h00, rd);
        $display("test registers done");
        self_test_enable_in <= 1'b1; repeat (2) settle; check(8'h01, {7'h0, self_test_active_out});
        self_test_enable_in <= 1'b0; repeat (2) settle; check(8'h00, {7'h0, self_test_active_out});
        $display("test self-test done");
        power_down_n_in <= 1'b0;
        settle;
        check(8'h03, {6'h0, serial_p_out, serial_n_out});
        check(8'h00, {7'h0, pll_enable_out});
        // Write while down must be dropped
        reg_write(CTRL0_OFFSET, 8'h2d);
        power_down_n_in <= 1'b1;
        settle;
        reg_read(CTRL0_OFFSET); check(CTRL0_RESET, rd);
        reg_read(CTRL1_OFFSET); check(CTRL1_RESET, rd);
        check(8'h00, {6'h0, link_mode_out});
        check(8'h01, {7'h0, serial_p_out ^ serial_n_out});
        reg_write(CTRL0_OFFSET, 8'h2d); settle; check(8'h03, {6'h0, link_mode_out});
        $display("test power-down done");
        stop_test();
    end
    // Whole sequence needs well under 1000 cycles
    initial begin
        #2000000;
        num_errors++;
        stop_test();
    end
endmodule : tb_top
